// [core/cmu_decode.sv]
// instruction field decode and effective address adder
`timescale 1ns/1ns
module cmu_decode
    import cmu_pkg::*;
(
    input wire cmu_req_t req,
    output logic [ADDR_W-1:0] eff_addr,
    output logic [1:0] cache_sel,
    output logic [2:0] op_code
);
    always_comb begin
        eff_addr = req.base + {{(ADDR_W-OFFS_W){req.instr[OFFS_W-1]}},
                               req.instr[OFFS_W-1:0]};
        cache_sel = req.instr[SEL_LSB+1:SEL_LSB];
        op_code = req.instr[OP_LSB+2:OP_LSB];
    end
endmodule

// [core/cmu_fault.sv]
// translation and address fault classification
`timescale 1ns/1ns
module cmu_fault
    import cmu_pkg::*;
(
    input wire logic xlat_refill,
    input wire logic xlat_invalid,
    input wire logic kseg_protected,
    input wire logic kaddr_check_en,
    output cmu_exc_t exc
);
    always_comb begin
        exc.code = EXC_NONE;
        exc.cause = 5'h00;
        if (kaddr_check_en && kseg_protected) begin
            exc.code = EXC_ADDR;
            exc.cause = address_fault_load_cause;
        end else if (xlat_refill) begin
            exc.code = EXC_TLB_REFILL;
            exc.cause = translation_fault_load_cause;
        end else if (xlat_invalid) begin
            exc.code = EXC_TLB_INVALID;
            exc.cause = translation_fault_load_cause;
        end
    end
endmodule

// [core/cmu_pkg.sv]
// constants, types and operation list for the cache maintenance unit
package cmu_pkg;
    localparam int ADDR_W = 64;
    localparam int OFFS_W = 16;
    localparam int SEL_LSB = 16;
    localparam int OP_LSB = 18;
    localparam int TAG_W = 32;
    localparam int DATA_W = 64;

    localparam logic [1:0] CACHE_INSTR = 2'h0;
    localparam logic [1:0] CACHE_DATA = 2'h1;
    localparam logic [1:0] CACHE_TERT = 2'h2;
    localparam logic [1:0] CACHE_SEC = 2'h3;

    localparam logic [2:0] OP_IDX_INV = 3'h0;
    localparam logic [2:0] OP_IDX_LDTAG = 3'h1;
    localparam logic [2:0] OP_IDX_STTAG = 3'h2;
    localparam logic [2:0] OP_IMPL = 3'h3;
    localparam logic [2:0] OP_HIT_INV = 3'h4;
    localparam logic [2:0] OP_FILL_HWBI = 3'h5;
    localparam logic [2:0] OP_HIT_WB = 3'h6;
    localparam logic [2:0] OP_FETCH_LOCK = 3'h7;

    // exception codes on the fault port
    localparam logic [2:0] EXC_NONE = 3'h0;
    localparam logic [2:0] EXC_TLB_REFILL = 3'h1;
    localparam logic [2:0] EXC_TLB_INVALID = 3'h2;
    localparam logic [2:0] EXC_ADDR = 3'h3;
    localparam logic [2:0] EXC_CACHE_ERR = 3'h4;
    localparam logic [2:0] EXC_BUS_ERR = 3'h5;

    // cause codes: translation fault load and store, address fault load
    localparam logic [4:0] translation_fault_load_cause = 5'h02;
    localparam logic [4:0] translation_fault_store_cause = 5'h03;
    localparam logic [4:0] address_fault_load_cause = 5'h04;

    // tag word layout: lock, dirty, valid, address tag
    localparam int TAG_VALID_BIT = 0;
    localparam int TAG_DIRTY_BIT = 1;
    localparam int TAG_LOCK_BIT = 2;
    localparam int TAG_ADDR_LSB = 8;
    localparam logic [TAG_W-1:0] TAG_RESET = 32'h0000_0000;

    typedef struct packed {
        logic [31:0] instr;
        logic [ADDR_W-1:0] base;
    } cmu_req_t;

    typedef struct packed {
        logic valid;
        logic dirty;
        logic lock;
        logic [TAG_W-1:0] tag_lo;
        logic [TAG_W-1:0] tag_hi;
    } cmu_line_t;

    typedef struct packed {
        logic [2:0] code;
        logic [4:0] cause;
    } cmu_exc_t;
endpackage

// [core/cmu_unit.sv]
// cache maintenance sequencer: lookup, writeback, fill, tag update
`timescale 1ns/1ns
module cmu_unit
    import cmu_pkg::*;
(
    input wire logic core_clk,
    input wire logic sys_rst,
    // pipeline side
    input wire logic req_valid,
    output logic req_ready,
    input wire cmu_req_t req,
    input wire logic xlat_refill,
    input wire logic xlat_invalid,
    input wire logic [ADDR_W-1:0] phys_addr,
    input wire logic kseg_protected,
    input wire logic kaddr_check_en,
    input wire logic [3:0] wb_cache_mask,
    output logic done,
    output cmu_exc_t exc_out,
    // holding words
    input wire logic [TAG_W-1:0] tag_word_lower,
    input wire logic [TAG_W-1:0] tag_word_upper,
    output logic [TAG_W-1:0] tag_word_lower_rd,
    output logic [TAG_W-1:0] tag_word_upper_rd,
    output logic [DATA_W/2-1:0] line_data_lower,
    output logic [DATA_W/2-1:0] line_data_upper,
    output logic hold_load,
    // cache array side
    output logic arr_req,
    output logic [1:0] arr_sel,
    output logic [ADDR_W-1:0] arr_addr,
    input wire logic arr_ack,
    input wire logic arr_hit,
    input wire cmu_line_t arr_line,
    input wire logic [DATA_W-1:0] arr_data,
    input wire logic arr_err,
    output logic arr_wr,
    output cmu_line_t arr_wline,
    // memory bus side
    output logic bus_req,
    output logic bus_write,
    output logic [ADDR_W-1:0] bus_addr,
    input wire logic bus_ack,
    input wire logic bus_err
);
    typedef enum logic [2:0] {
        S_IDLE, S_LOOK, S_WB, S_FILL, S_UPD, S_DONE
    } cmu_state_t;

    logic [ADDR_W-1:0] eff_addr;
    logic [1:0] cache_sel;
    logic [2:0] op_code;
    cmu_exc_t xlat_exc;

    cmu_state_t state_r, state_nxt;
    logic [1:0] sel_r, sel_nxt;
    logic [2:0] op_r, op_nxt;
    logic [ADDR_W-1:0] addr_r, addr_nxt;
    cmu_line_t line_r, line_nxt;
    logic hit_r, hit_nxt;
    cmu_exc_t exc_r, exc_nxt;
    logic done_r, done_nxt;
    logic [TAG_W-1:0] tlo_r, tlo_nxt;
    logic [TAG_W-1:0] thi_r, thi_nxt;
    logic [DATA_W-1:0] dat_r, dat_nxt;
    logic hold_r, hold_nxt;
    logic wr_r, wr_nxt;
    logic wb_cache;

    cmu_decode u_dec (
        .req(req),
        .eff_addr(eff_addr),
        .cache_sel(cache_sel),
        .op_code(op_code)
    );

    cmu_fault u_flt (
        .xlat_refill(xlat_refill),
        .xlat_invalid(xlat_invalid),
        .kseg_protected(kseg_protected),
        .kaddr_check_en(kaddr_check_en),
        .exc(xlat_exc)
    );

    // write-back policy per cache; instr cache never write-back
    assign wb_cache = wb_cache_mask[sel_r] && (sel_r != CACHE_INSTR);

    assign req_ready = (state_r == S_IDLE);
    assign done = done_r;
    assign exc_out = exc_r;
    assign tag_word_lower_rd = tlo_r;
    assign tag_word_upper_rd = thi_r;
    assign line_data_lower = dat_r[DATA_W/2-1:0];
    assign line_data_upper = dat_r[DATA_W-1:DATA_W/2];
    assign hold_load = hold_r;
    assign arr_sel = sel_r;
    assign arr_addr = addr_r;
    assign arr_req = (state_r == S_LOOK);
    // strobe after update, so the written line is final
    assign arr_wr = wr_r;
    assign arr_wline = line_r;
    assign bus_req = (state_r == S_WB) || (state_r == S_FILL);
    assign bus_write = (state_r == S_WB);
    // writeback goes to the address held in the tag
    assign bus_addr = (state_r == S_WB) ?
        {{(ADDR_W-TAG_W){1'b0}}, line_r.tag_lo} : addr_r;

    always_comb begin
        state_nxt = state_r;
        sel_nxt = sel_r;
        op_nxt = op_r;
        addr_nxt = addr_r;
        line_nxt = line_r;
        hit_nxt = hit_r;
        exc_nxt = exc_r;
        done_nxt = 1'b0;
        tlo_nxt = tlo_r;
        thi_nxt = thi_r;
        dat_nxt = dat_r;
        hold_nxt = 1'b0;
        wr_nxt = 1'b0;
        case (state_r)
            S_IDLE: begin
                if (req_valid) begin
                    sel_nxt = cache_sel;
                    op_nxt = op_code;
                    exc_nxt = xlat_exc;
                    // index ops may use the untranslated address
                    addr_nxt = op_code[2] ? phys_addr : eff_addr;
                    if (xlat_exc.code != EXC_NONE) begin
                        state_nxt = S_DONE;
                    end else if (op_code == OP_IMPL) begin
                        state_nxt = S_DONE;
                    end else begin
                        state_nxt = S_LOOK;
                    end
                end
            end
            S_LOOK: begin
                if (arr_ack) begin
                    line_nxt = arr_line;
                    // index ops ignore the tag compare
                    hit_nxt = op_r[2] ? (arr_hit && arr_line.valid)
                                      : 1'b1;
                    state_nxt = S_UPD;
                    if (arr_err) begin
                        exc_nxt.code = EXC_CACHE_ERR;
                        exc_nxt.cause = 5'h00;
                        state_nxt = S_DONE;
                    end else begin
                        case (op_r)
                            OP_IDX_INV: begin
                                if (wb_cache && arr_line.valid &&
                                    arr_line.dirty) begin
                                    state_nxt = S_WB;
                                end
                            end
                            OP_IDX_LDTAG: begin
                                // copy tag and data to holders
                                tlo_nxt = arr_line.tag_lo;
                                thi_nxt = arr_line.tag_hi;
                                dat_nxt = arr_data;
                                hold_nxt = 1'b1;
                                state_nxt = S_DONE;
                            end
                            OP_IDX_STTAG: state_nxt = S_UPD;
                            OP_HIT_INV: begin
                                if (!(arr_hit && arr_line.valid)) begin
                                    state_nxt = S_DONE;
                                end
                            end
                            OP_FILL_HWBI: begin
                                if (sel_r == CACHE_INSTR) begin
                                    state_nxt = S_FILL;
                                end else if (!(arr_hit && arr_line.valid)) begin
                                    state_nxt = S_DONE;
                                end else if (wb_cache && arr_line.dirty) begin
                                    state_nxt = S_WB;
                                end
                            end
                            OP_HIT_WB: begin
                                // only a dirty hit on write-back cache
                                if (wb_cache && arr_hit && arr_line.valid &&
                                    arr_line.dirty) begin
                                    state_nxt = S_WB;
                                end else begin
                                    state_nxt = S_DONE;
                                end
                            end
                            default: begin
                                if (arr_hit && arr_line.valid) begin
                                    state_nxt = S_UPD;
                                end else if (wb_cache && arr_line.valid &&
                                             arr_line.dirty) begin
                                    state_nxt = S_WB;
                                end else begin
                                    state_nxt = S_FILL;
                                end
                            end
                        endcase
                    end
                end
            end
            S_WB: begin
                if (bus_ack) begin
                    if (bus_err) begin
                        // writeback fault is a cache error
                        exc_nxt.code = EXC_CACHE_ERR;
                        exc_nxt.cause = 5'h00;
                        state_nxt = S_DONE;
                    end else if (op_r == OP_FETCH_LOCK) begin
                        state_nxt = S_FILL;
                    end else begin
                        state_nxt = S_UPD;
                    end
                end
            end
            S_FILL: begin
                if (bus_ack) begin
                    if (bus_err) begin
                        // failed fill is a bus error
                        exc_nxt.code = EXC_BUS_ERR;
                        exc_nxt.cause = 5'h00;
                        state_nxt = S_DONE;
                    end else begin
                        line_nxt.tag_lo = addr_r[TAG_W-1:0];
                        line_nxt.dirty = 1'b0;
                        hit_nxt = 1'b0;
                        state_nxt = S_UPD;
                    end
                end
            end
            S_UPD: begin
                case (op_r)
                    OP_IDX_STTAG: begin
                        line_nxt.tag_lo = tag_word_lower;
                        line_nxt.tag_hi = tag_word_upper;
                        line_nxt.valid = tag_word_lower[TAG_VALID_BIT];
                        line_nxt.dirty = tag_word_lower[TAG_DIRTY_BIT];
                        line_nxt.lock = tag_word_lower[TAG_LOCK_BIT];
                    end
                    OP_HIT_WB: line_nxt.dirty = 1'b0;
                    OP_FETCH_LOCK: begin
                        line_nxt.valid = 1'b1;
                        line_nxt.lock = 1'b1;
                    end
                    OP_FILL_HWBI: begin
                        if (sel_r == CACHE_INSTR) begin
                            line_nxt.valid = 1'b1;
                            line_nxt.dirty = 1'b0;
                            line_nxt.lock = 1'b0;
                        end else begin
                            line_nxt.valid = 1'b0;
                            line_nxt.dirty = 1'b0;
                            line_nxt.lock = 1'b0;
                        end
                    end
                    default: begin
                        line_nxt.valid = 1'b0;
                        line_nxt.dirty = 1'b0;
                        line_nxt.lock = 1'b0;
                    end
                endcase
                wr_nxt = 1'b1;
                state_nxt = S_DONE;
            end
            S_DONE: begin
                done_nxt = 1'b1;
                state_nxt = S_IDLE;
            end
            default: state_nxt = S_IDLE;
        endcase
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            state_r <= S_IDLE;
            sel_r <= CACHE_INSTR;
            op_r <= OP_IDX_INV;
            addr_r <= '0;
            line_r <= '0;
            hit_r <= 1'b0;
            exc_r <= '0;
            done_r <= 1'b0;
            tlo_r <= TAG_RESET;
            thi_r <= TAG_RESET;
            dat_r <= '0;
            hold_r <= 1'b0;
            wr_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            sel_r <= sel_nxt;
            op_r <= op_nxt;
            addr_r <= addr_nxt;
            line_r <= line_nxt;
            hit_r <= hit_nxt;
            exc_r <= exc_nxt;
            done_r <= done_nxt;
            tlo_r <= tlo_nxt;
            thi_r <= thi_nxt;
            dat_r <= dat_nxt;
            hold_r <= hold_nxt;
            wr_r <= wr_nxt;
        end
    end
endmodule

// [test/cmu_far_model.sv]
// cache array and memory bus responder facing the unit
`timescale 1ns/1ns
module cmu_far_model
    import cmu_pkg::*;
(
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic arr_req,
    input wire logic bus_req,
    input wire logic cfg_hit,
    input wire cmu_line_t cfg_line,
    input wire logic [DATA_W-1:0] cfg_data,
    input wire logic cfg_aerr,
    input wire logic cfg_berr,
    input wire logic [1:0] cfg_slow,
    output logic arr_ack,
    output logic arr_hit,
    output cmu_line_t arr_line,
    output logic [DATA_W-1:0] arr_data,
    output logic arr_err,
    output logic bus_ack,
    output logic bus_err
);
    logic [1:0] wait_r;
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            wait_r <= '0;
            {arr_ack, arr_hit, arr_line, arr_data, arr_err} <= '0;
            {bus_ack, bus_err} <= '0;
        end else begin
            arr_ack <= 1'b0;
            bus_ack <= 1'b0;
            // answers are only good in the ack cycle
            {arr_hit, arr_line, arr_data} <= ~{arr_hit, arr_line, arr_data};
            {arr_err, bus_err} <= ~{arr_err, bus_err};
            if ((arr_req && !arr_ack) || (bus_req && !bus_ack)) begin
                wait_r <= wait_r + 2'h1;
                if (wait_r == cfg_slow) begin
                    wait_r <= '0;
                    arr_ack <= arr_req;
                    bus_ack <= !arr_req;
                    {arr_hit, arr_line, arr_data} <= {cfg_hit, cfg_line,
                        cfg_data};
                    {arr_err, bus_err} <= {cfg_aerr, cfg_berr};
                end
            end
        end
    end
endmodule

// [test/cmu_unit_monitor.sv]
// port-level checks on the cache maintenance unit
`timescale 1ns/1ns
module cmu_unit_monitor
    import cmu_pkg::*;
(
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic req_valid,
    input wire logic req_ready,
    input wire cmu_req_t req,
    input wire logic xlat_refill,
    input wire logic xlat_invalid,
    input wire logic [ADDR_W-1:0] phys_addr,
    input wire logic kseg_protected,
    input wire logic kaddr_check_en,
    input wire logic done,
    input wire cmu_exc_t exc_out,
    input wire logic arr_req,
    input wire logic [1:0] arr_sel,
    input wire logic [ADDR_W-1:0] arr_addr,
    input wire logic arr_ack,
    input wire logic arr_err,
    input wire logic arr_wr,
    input wire logic bus_req,
    input wire logic bus_write,
    input wire logic [ADDR_W-1:0] bus_addr,
    input wire logic bus_ack,
    input wire logic bus_err
);
    logic take;
    logic [2:0] op_r;
    logic [1:0] sel_r;
    logic [ADDR_W-1:0] adr_r;
    assign take = req_valid && req_ready;
    // target captured when a request is taken
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            op_r <= '0;
            sel_r <= '0;
            adr_r <= '0;
        end else if (take) begin
            op_r <= req.instr[20:18];
            sel_r <= req.instr[17:16];
            adr_r <= req.instr[20] ? phys_addr
                : req.base + {{48{req.instr[15]}}, req.instr[15:0]};
        end
    end
    default clocking @(posedge core_clk); endclocking
    default disable iff (sys_rst);
    sequence wb_ok_s;
        bus_req && bus_write && bus_ack && !bus_err;
    endsequence
    sequence finish_s;
        arr_wr ##1 done;
    endsequence
    busy_refuse_a: assert property (take |=> !req_ready)
        else $error("request taken while busy");
    done_pulse_a: assert property (done |=> !done)
        else $error("done longer than one cycle");
    wb_then_write_a: assert property (
        wb_ok_s ##0 (op_r != OP_FETCH_LOCK) |-> ##2 finish_s)
        else $error("no line update after writeback");
    wb_err_code_a: assert property (
        bus_req && bus_write && bus_ack && bus_err
        |-> ##[1:3] (done && exc_out.code == EXC_CACHE_ERR))
        else $error("writeback fault not a cache error");
    fill_err_code_a: assert property (
        bus_req && !bus_write && bus_ack && bus_err
        |-> ##[1:3] (done && exc_out.code == EXC_BUS_ERR))
        else $error("fill fault not a bus error");
    arr_err_code_a: assert property (
        arr_req && arr_ack && arr_err
        |=> !arr_wr ##[0:2] (done && exc_out.code == EXC_CACHE_ERR))
        else $error("array fault handled wrongly");
    refill_load_a: assert property (
        take && xlat_refill && !xlat_invalid
        && !(kseg_protected && kaddr_check_en) |-> ##[2:4]
        (done && exc_out == {EXC_TLB_REFILL, translation_fault_load_cause}))
        else $error("refill fault not reported");
    addr_fault_a: assert property (
        take && kseg_protected && kaddr_check_en |-> ##[2:4]
        (done && exc_out == {EXC_ADDR, address_fault_load_cause}))
        else $error("address fault not reported");
    no_store_cause_a: assert property (
        done |-> exc_out.cause != translation_fault_store_cause)
        else $error("store cause reported");
    lookup_target_a: assert property (
        arr_req |-> arr_sel == sel_r && arr_addr == adr_r)
        else $error("lookup target wrong");
    bus_hold_a: assert property (
        bus_req && !bus_ack |=> bus_req && $stable(bus_addr) && !done)
        else $error("bus request dropped early");
endmodule
bind cmu_unit cmu_unit_monitor i_cmu_unit_monitor (.*);

// [test/tb.sv]
// self-checking bench for the cache maintenance unit
`timescale 1ns/1ns
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin err_count++; \
    $display("[ERR] t=%0t got %h exp %h", $time, a, b); end end
module tb;
    import cmu_pkg::*;
    logic core_clk, sys_rst, req_valid, req_ready, xlat_refill, xlat_invalid;
    logic kseg_protected, kaddr_check_en, done, hold_load, arr_req, arr_ack;
    logic arr_hit, arr_err, arr_wr, bus_req, bus_write, bus_ack, bus_err;
    logic cfg_hit, cfg_aerr, cfg_berr, e_wb, e_fill, e_wr, e_v, e_d, e_l;
    logic [1:0] arr_sel, cfg_slow, look_sel;
    logic [2:0] e_code;
    logic [3:0] wb_cache_mask;
    logic [4:0] e_cause;
    logic [15:0] seed;
    logic [ADDR_W-1:0] phys_addr, arr_addr, bus_addr, wb_addr, fill_addr;
    logic [ADDR_W-1:0] look_addr;
    logic [TAG_W-1:0] tag_word_lower, tag_word_upper;
    logic [TAG_W-1:0] tag_word_lower_rd, tag_word_upper_rd;
    logic [DATA_W/2-1:0] line_data_lower, line_data_upper;
    logic [DATA_W-1:0] arr_data, cfg_data;
    cmu_req_t req;
    cmu_line_t arr_line, arr_wline, cfg_line, wl;
    cmu_exc_t exc_out;
    int err_count, checked, n_wb, n_fill, n_wr, n_ld;
    cmu_unit i_cmu_unit (.*);
    cmu_far_model i_cmu_far_model (.*);
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    always @(posedge core_clk) begin
        if (bus_req && bus_ack && bus_write) begin
            n_wb++;
            wb_addr = bus_addr;
        end
        if (bus_req && bus_ack && !bus_write) begin
            n_fill++;
            fill_addr = bus_addr;
        end
        n_ld += hold_load;
        if (arr_wr) begin
            n_wr++;
            wl = arr_wline;
        end
        if (arr_req) begin
            look_addr = arr_addr;
            look_sel = arr_sel;
        end
    end
    function automatic logic [15:0] rn();
        seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
        return seed;
    endfunction
    function automatic void predict(logic [2:0] op, logic [1:0] sel,
                                    logic [1:0] f);
        logic d;
        d = cfg_line.valid && cfg_line.dirty && sel != CACHE_INSTR
            && wb_cache_mask[sel];
        {e_wb, e_fill, e_wr, e_v, e_d, e_l} = '0;
        e_code = {1'b0, f};
        e_cause = f == 2'h3 ? address_fault_load_cause
            : translation_fault_load_cause;
        if (f != 2'h0 || op == OP_IMPL)
            return;
        e_code = cfg_aerr ? EXC_CACHE_ERR : EXC_NONE;
        if (cfg_aerr)
            return;
        case (op)
            OP_IDX_INV: {e_wb, e_wr} = {d, 1'b1};
            OP_IDX_STTAG: {e_wr, e_l, e_d, e_v} = {1'b1, tag_word_lower[2:0]};
            OP_HIT_INV: e_wr = cfg_hit;
            OP_FILL_HWBI: begin
                e_fill = sel == CACHE_INSTR;
                e_wb = !e_fill && cfg_hit && d;
                {e_wr, e_v} = {e_fill || cfg_hit, e_fill};
            end
            OP_HIT_WB: {e_wb, e_wr, e_v, e_l} = {{2{cfg_hit && d}}, 1'b1,
                cfg_line.lock};
            OP_FETCH_LOCK: begin
                {e_fill, e_wb} = {!cfg_hit, !cfg_hit && d};
                {e_wr, e_v, e_l} = 3'h7;
                e_d = cfg_hit && cfg_line.dirty;
            end
            default: ;
        endcase
        if (cfg_berr && (e_wb || e_fill)) begin
            e_code = e_wb ? EXC_CACHE_ERR : EXC_BUS_ERR;
            {e_fill, e_wr} = {e_fill && !e_wb, 1'b0};
        end
    endfunction
    task automatic run(logic [2:0] op, logic [1:0] sel, logic [1:0] f,
        logic hit, logic vd, logic ae, logic be, logic [3:0] mk);
        int n;
        logic [31:0] t;
        logic [ADDR_W-1:0] ea, pa;
        cmu_req_t r;
        {n_wb, n_fill, n_wr, n_ld, look_addr} = '0;
        t = {rn(), rn()};
        t[1:0] = t[1:0] | {vd, hit | vd};
        cfg_line = '{t[0], t[1], t[2], t, {rn(), rn()}};
        cfg_data = {rn(), rn(), rn(), rn()};
        {cfg_hit, cfg_aerr, cfg_berr, cfg_slow} = {hit, ae, be, seed[1:0]};
        r.instr = {11'h5e, op, sel, rn()};
        r.base = {rn(), rn(), rn(), rn()};
        ea = r.base + {{48{r.instr[15]}}, r.instr[15:0]};
        pa = {rn(), rn(), rn(), rn()};
        `CHK(req_ready, 1'b1)
        @(posedge core_clk);
        req_valid <= 1'b1;
        req <= r;
        phys_addr <= pa;
        {xlat_refill, xlat_invalid} <= {f == 2'h1, f == 2'h2};
        {kseg_protected, kaddr_check_en} <= {f == 2'h3 || seed[0], f == 2'h3};
        wb_cache_mask <= mk;
        {tag_word_lower, tag_word_upper} <= {rn(), rn(), rn(), rn()};
        @(posedge core_clk);
        req_valid <= 1'b0;
        predict(op, sel, f);
        n = 0;
        do begin
            @(negedge core_clk);
            n++;
        end while (done !== 1'b1 && n < 60);
        `CHK(done, 1'b1)
        `CHK(exc_out.code, e_code)
        if (f != 2'h0)
            `CHK(exc_out.cause, e_cause)
        `CHK(n_wb, e_wb)
        `CHK(n_fill, e_fill)
        `CHK(n_wr, e_wr)
        if (e_wr)
            `CHK({wl.valid, wl.lock}, {e_v, e_l})
        if (e_wr && e_v)
            `CHK(wl.dirty, e_d)
        if (e_wb)
            `CHK(wb_addr, {32'h0, cfg_line.tag_lo})
        if (e_fill)
            `CHK(fill_addr, pa)
        if (f == 2'h0 && op != OP_IMPL)
            `CHK({look_sel, look_addr}, {sel, op[2] ? pa : ea})
        if (op == OP_IDX_STTAG && e_wr)
            `CHK({wl.tag_hi, wl.tag_lo}, {tag_word_upper, tag_word_lower})
        `CHK(n_ld, op == OP_IDX_LDTAG && e_code == EXC_NONE)
        if (op == OP_IDX_LDTAG && e_code == EXC_NONE)
            `CHK({tag_word_upper_rd, tag_word_lower_rd, line_data_upper,
                line_data_lower}, {cfg_line.tag_hi, cfg_line.tag_lo,
                cfg_data})
    endtask
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    initial begin
        #400000;
        err_count++;
        give_verdict();
    end
    initial begin
        logic [15:0] s;
        seed = 16'd33577;
        sys_rst = 1'b1;
        {req_valid, req, xlat_refill, xlat_invalid, phys_addr} = '0;
        {kseg_protected, kaddr_check_en, wb_cache_mask} = '0;
        {tag_word_lower, tag_word_upper, cfg_hit, cfg_line, cfg_data} = '0;
        {cfg_aerr, cfg_berr, cfg_slow} = '0;
        repeat (10) @(posedge core_clk);
        sys_rst <= 1'b0;
        @(negedge core_clk);
        `CHK(done, 1'b0)
        run(3'h0, 2'h1, 2'h0, 1'b0, 1'b1, 1'b0, 1'b0, 4'hf);
        run(3'h0, 2'h2, 2'h0, 1'b0, 1'b1, 1'b0, 1'b0, 4'h0);
        run(3'h0, 2'h0, 2'h0, 1'b0, 1'b1, 1'b0, 1'b0, 4'hf);
        run(3'h1, 2'h3, 2'h0, 1'b0, 1'b0, 1'b0, 1'b0, 4'hf);
        run(3'h2, 2'h1, 2'h0, 1'b0, 1'b0, 1'b0, 1'b0, 4'hf);
        run(3'h3, 2'h1, 2'h0, 1'b1, 1'b1, 1'b0, 1'b0, 4'hf);
        run(3'h4, 2'h1, 2'h0, 1'b0, 1'b1, 1'b0, 1'b0, 4'hf);
        run(3'h4, 2'h0, 2'h0, 1'b1, 1'b0, 1'b0, 1'b0, 4'hf);
        run(3'h5, 2'h0, 2'h0, 1'b0, 1'b0, 1'b0, 1'b0, 4'hf);
        run(3'h5, 2'h1, 2'h0, 1'b1, 1'b1, 1'b0, 1'b0, 4'hf);
        run(3'h6, 2'h3, 2'h0, 1'b1, 1'b1, 1'b0, 1'b0, 4'hf);
        run(3'h6, 2'h3, 2'h0, 1'b1, 1'b1, 1'b0, 1'b0, 4'h0);
        run(3'h7, 2'h1, 2'h0, 1'b0, 1'b1, 1'b0, 1'b0, 4'hf);
        run(3'h7, 2'h0, 2'h0, 1'b1, 1'b0, 1'b0, 1'b0, 4'hf);
        run(3'h0, 2'h1, 2'h1, 1'b0, 1'b0, 1'b0, 1'b0, 4'hf);
        run(3'h5, 2'h1, 2'h2, 1'b1, 1'b0, 1'b0, 1'b0, 4'hf);
        run(3'h4, 2'h1, 2'h3, 1'b1, 1'b0, 1'b0, 1'b0, 4'hf);
        run(3'h0, 2'h1, 2'h0, 1'b0, 1'b0, 1'b1, 1'b0, 4'hf);
        run(3'h0, 2'h1, 2'h0, 1'b0, 1'b1, 1'b0, 1'b1, 4'hf);
        run(3'h5, 2'h0, 2'h0, 1'b0, 1'b0, 1'b0, 1'b1, 4'hf);
        repeat (250) begin
            s = rn();
            run(s[2:0], s[4:3], (s[15] && s[14]) ? s[13:12] : 2'h0, s[5],
                s[6], s[15:12] == 4'h1, s[15:12] == 4'h2, s[11:8]);
        end
        give_verdict();
    end
endmodule
